// ===== core/dcc_channel_control.sv
// Purpose: Trigger latches, width timers, masks and dataway registers of a 16-channel discriminator.
// Assumes: Comparator outputs idle high and fall when an input crosses threshold.
// Notes:   The analog ramp is replaced by a cycle counter loaded from the width code.
`timescale 1ns/1ps
`default_nettype none

module dcc_channel_control
(
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  input  wire dcc_pkg::dcc_dataway_t             dataway,
  input  wire logic [dcc_pkg::NUM_CHAN-1:0]      write_data_bits,
  input  wire logic [dcc_pkg::NUM_CHAN-1:0]      comp_out,
  input  wire logic                              front_veto,
  input  wire logic [dcc_pkg::NUM_CHAN-1:0]      rear_inhibit,
  input  wire logic                              front_test,
  input  wire logic                              remote_mode,
  input  wire logic [dcc_pkg::SETTING_W-1:0]     manual_threshold,
  input  wire logic [dcc_pkg::SETTING_W-1:0]     manual_width,
  output logic      [dcc_pkg::NUM_CHAN-1:0]      read_data_bits,
  output logic                                   q,
  output logic                                   x,
  output logic      [dcc_pkg::NUM_CHAN-1:0]      channel_out,
  output logic      [dcc_pkg::SETTING_W-1:0]     threshold_control_level,
  output logic      [dcc_pkg::SETTING_W-1:0]     width_control_level
);

  dcc_pkg::dcc_state_t                st;
  dcc_pkg::dcc_state_t                next_st;
  logic                               wr_strobe;
  logic                               rd_cycle;
  logic                               a_ok;
  logic                               inh_common;
  logic                               test_req;
  logic [dcc_pkg::NUM_CHAN-1:0]       mask_eff;
  logic [dcc_pkg::NUM_CHAN-1:0]       fall;
  logic [dcc_pkg::NUM_CHAN-1:0]       d_in;
  logic [dcc_pkg::SETTING_W-1:0]      width_sel;
  logic [23:0]                        width_prod;
  logic [23:0]                        width_div;
  logic [dcc_pkg::TIMER_W-1:0]        width_cyc;

  // Dataway decode; q and x answer combinationally while the station is addressed.
  assign a_ok       = (dataway.a <= dcc_pkg::SA_MODE);
  assign wr_strobe  = dataway.n && (dataway.f == dcc_pkg::FN_WRITE) && dataway.s1;
  assign rd_cycle   = dataway.n && (dataway.f == dcc_pkg::FN_READ);
  assign q          = dataway.n && ((a_ok && (dataway.f == dcc_pkg::FN_READ || dataway.f == dcc_pkg::FN_WRITE))
                      || dataway.f == dcc_pkg::FN_TEST);
  assign x          = dataway.n && (dataway.f == dcc_pkg::FN_READ || dataway.f == dcc_pkg::FN_WRITE
                      || dataway.f == dcc_pkg::FN_TEST);

  // The common inhibit only acts in remote mode; test ignores it and the veto.
  assign inh_common = dataway.i && remote_mode;
  assign mask_eff   = rear_inhibit | st.mask;
  assign test_req   = front_test || (remote_mode && dataway.n && (dataway.f == dcc_pkg::FN_TEST) && dataway.s1);
  assign fall       = st.prev_comp & ~comp_out;

  // Width code to cycles: the map is inverted so a larger code gives a shorter pulse.
  assign width_sel  = remote_mode ? st.width : manual_width;
  assign width_prod = 24'(width_sel) * 24'(dcc_pkg::WIDTH_MAX_CYC - dcc_pkg::WIDTH_MIN_CYC);
  assign width_div  = width_prod / 24'(dcc_pkg::CODE_FULL_SCALE);
  assign width_cyc  = dcc_pkg::TIMER_W'(dcc_pkg::WIDTH_MAX_CYC) - width_div[dcc_pkg::TIMER_W-1:0];

  // Next state of channels and registers.
  always_comb
  begin
    next_st           = st;
    next_st.prev_comp = comp_out;
    for (int k = 0; k < dcc_pkg::NUM_CHAN; k++)
    begin
      // Latch data gate: veto, common inhibit and mask all force it false.
      d_in[k] = !front_veto && !inh_common && !mask_eff[k]
                && (st.mode[dcc_pkg::MODE_UPDATE_BIT] || !st.active[k]);
      // Test sets the latch directly; only the channel mask or the rear inhibit stops it.
      next_st.latch[k] = (fall[k] && d_in[k]) || (test_req && !mask_eff[k]);
      // A set latch starts a full width from its crossing and is gone next cycle.
      if (st.latch[k])
      begin
        next_st.timer[k] = width_cyc;
      end
      else if (st.mode[dcc_pkg::MODE_BURST_BIT] && !comp_out[k] && st.active[k])
      begin
        // Burst guard: the pulse lasts at least as long as the input stays over threshold.
        next_st.timer[k] = st.timer[k];
      end
      else if (st.timer[k] != '0)
      begin
        next_st.timer[k] = st.timer[k] - dcc_pkg::TIMER_W'(1);
      end
      next_st.active[k] = (next_st.timer[k] != '0);
    end
    // Register writes are stored whatever the mode, so remote picks them up later.
    if (wr_strobe)
    begin
      unique case (dataway.a)
        dcc_pkg::SA_MASK:   next_st.mask   = write_data_bits;
        dcc_pkg::SA_THRESH: next_st.thresh = write_data_bits[dcc_pkg::SETTING_W-1:0];
        dcc_pkg::SA_WIDTH:  next_st.width  = write_data_bits[dcc_pkg::SETTING_W-1:0];
        dcc_pkg::SA_MODE:   next_st.mode   = write_data_bits[dcc_pkg::MODE_W-1:0];
        default:            next_st.mode   = st.mode;
      endcase
    end
    // Clear and initialize are broadcast, so they ignore the station line.
    if ((dataway.c || dataway.z) && dataway.s2)
    begin
      next_st.mask = dcc_pkg::MASK_RST;
    end
    // Read data follows the addressed register while the read lasts.
    next_st.rd = '0;
    if (rd_cycle)
    begin
      unique case (dataway.a)
        dcc_pkg::SA_MASK:   next_st.rd = st.mask;
        dcc_pkg::SA_THRESH: next_st.rd = dcc_pkg::NUM_CHAN'(st.thresh);
        dcc_pkg::SA_WIDTH:  next_st.rd = dcc_pkg::NUM_CHAN'(st.width);
        dcc_pkg::SA_MODE:   next_st.rd = dcc_pkg::NUM_CHAN'(st.mode);
        default:            next_st.rd = '0;
      endcase
    end
    next_st.thr_out = remote_mode ? st.thresh : manual_threshold;
    next_st.wid_out = width_sel;
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st           <= '0;
      st.prev_comp <= '1;
      st.mask      <= dcc_pkg::MASK_RST;
      st.thresh    <= dcc_pkg::SETTING_RST;
      st.width     <= dcc_pkg::SETTING_RST;
      st.mode      <= dcc_pkg::MODE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign channel_out             = st.active;
  assign read_data_bits          = st.rd;
  assign threshold_control_level = st.thr_out;
  assign width_control_level     = st.wid_out;

  // Checks on channel 0 stand for all channels, which share one loop body.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  latch_fire_a: assert property (fall[0] && !front_veto && !inh_common && !mask_eff[0] && !st.active[0]
    |=> st.latch[0]) else $error("Crossing did not set the channel latch.");
  latch_clear_a: assert property (st.latch[0] && !test_req && !fall[0] |=> !st.latch[0])
    else $error("Latch stayed set after starting the timer.");
  veto_block_a: assert property (front_veto && !test_req |=> !st.latch[0])
    else $error("Veto did not block the latch.");
  inhibit_block_a: assert property (inh_common && !test_req |=> !st.latch[0])
    else $error("Common inhibit did not block the latch.");
  update_retrig_a: assert property (st.latch[0] && st.active[0] ##1 1 |-> st.timer[0] == $past(width_cyc))
    else $error("Retrigger did not reload a full width.");
  no_update_a: assert property (fall[0] && st.active[0] && !st.mode[dcc_pkg::MODE_UPDATE_BIT]
    && !test_req |=> !st.latch[0])
    else $error("Crossing during pulse extended it without update mode.");
  test_set_a: assert property (test_req && !mask_eff[0] |=> st.latch[0])
    else $error("Test did not set an unmasked channel.");
  test_mask_a: assert property (test_req && mask_eff[0] |=> !st.latch[0])
    else $error("Test fired a masked channel.");
  thr_source_a: assert property (1 |=> threshold_control_level == $past(remote_mode ? st.thresh : manual_threshold))
    else $error("Threshold level took the wrong source.");
  thr_write_a: assert property (wr_strobe && dataway.a == dcc_pkg::SA_THRESH
    |=> st.thresh == $past(write_data_bits[dcc_pkg::SETTING_W-1:0])) else $error("Threshold write lost.");
  wid_write_a: assert property (wr_strobe && dataway.a == dcc_pkg::SA_WIDTH
    |=> st.width == $past(write_data_bits[dcc_pkg::SETTING_W-1:0])) else $error("Width write lost.");
  width_span_a: assert property ((width_sel == dcc_pkg::CODE_FULL_SCALE)
    |-> width_cyc == dcc_pkg::TIMER_W'(dcc_pkg::WIDTH_MIN_CYC)) else $error("Full-scale code gave wrong width.");
  mask_hold_a: assert property (!(wr_strobe && dataway.a == dcc_pkg::SA_MASK) && !((dataway.c || dataway.z)
    && dataway.s2) |=> $stable(st.mask)) else $error("Mask changed without a write or clear.");
  mode_write_a: assert property (wr_strobe && dataway.a == dcc_pkg::SA_MODE
    |=> st.mode == $past(write_data_bits[dcc_pkg::MODE_W-1:0])) else $error("Mode write lost.");
  read_back_a: assert property (rd_cycle && dataway.a == dcc_pkg::SA_MASK |=> read_data_bits == $past(st.mask))
    else $error("Mask read returned wrong data.");
  pulse_len_a: assert property (st.latch[0] && !st.mode[dcc_pkg::MODE_BURST_BIT]
    && width_cyc == dcc_pkg::TIMER_W'(dcc_pkg::WIDTH_MAX_CYC) |=> st.active[0] [*3])
    else $error("Output pulse shorter than preset width.");
  // Burst guard must not let the timer run down while the input is still over threshold.
  burst_hold_a: assert property (st.mode[dcc_pkg::MODE_BURST_BIT] && !st.latch[0] && !comp_out[0]
    && st.active[0] |=> st.timer[0] == $past(st.timer[0])) else $error("Burst guard let the pulse end early.");
  width_long_a: assert property ((width_sel == '0)
    |-> width_cyc == dcc_pkg::TIMER_W'(dcc_pkg::WIDTH_MAX_CYC)) else $error("Zero code gave wrong width.");
  read_idle_a: assert property (!rd_cycle |=> read_data_bits == '0)
    else $error("Read data stood without a read.");
  station_idle_a: assert property (!dataway.n |-> !q && !x)
    else $error("Answer lines raised without the station selected.");

  // Covers mark the main scenarios that the bench is meant to reach.
  fire_c: cover property (fall[0] ##1 st.latch[0] ##1 st.active[0]);
  retrig_c: cover property (st.mode[0] && st.active[0] && st.latch[0]);
  test_c: cover property (test_req && (front_veto || inh_common) ##1 st.latch[0]);
  clear_c: cover property ((dataway.c || dataway.z) && dataway.s2 && st.mask != '0);
  burst_c: cover property (st.mode[dcc_pkg::MODE_BURST_BIT] && st.active[0] && !comp_out[0]);

endmodule

`default_nettype wire

// ===== core/dcc_pkg.sv
// Purpose: Shared constants and types for the discriminator channel control block.
// Assumes: One 25 MHz clock; dataway and channel inputs already synchronous to it.
// Notes:   Reset values of the setting registers are plain zeros.
package dcc_pkg;

  // Channel count and register widths.
  localparam int NUM_CHAN  = 16;
  localparam int SETTING_W = 12;
  localparam int MODE_W    = 2;
  localparam int TIMER_W   = 4;

  // Dataway function codes used by the block.
  localparam logic [4:0] FN_READ  = 5'h00;
  localparam logic [4:0] FN_WRITE = 5'h10;
  localparam logic [4:0] FN_TEST  = 5'h19;

  // Subaddresses of the setting registers.
  localparam logic [3:0] SA_MASK   = 4'h0;
  localparam logic [3:0] SA_THRESH = 4'h1;
  localparam logic [3:0] SA_WIDTH  = 4'h2;
  localparam logic [3:0] SA_MODE   = 4'h3;

  // Field positions inside the mode register (data bits 0 and 1).
  localparam int MODE_UPDATE_BIT = 0;
  localparam int MODE_BURST_BIT  = 1;

  // Reset values.
  localparam logic [NUM_CHAN-1:0]  MASK_RST    = 16'h0000;
  localparam logic [SETTING_W-1:0] SETTING_RST = 12'h000;
  localparam logic [MODE_W-1:0]    MODE_RST    = 2'h0;

  // Setting codes are unsigned and linear; this code is converter full scale.
  localparam logic [SETTING_W-1:0] CODE_FULL_SCALE = 12'hFFF;

  // Output width span and its conversion to clock cycles.
  localparam int CLK_PERIOD_NS = 40;
  localparam int WIDTH_MIN_NS  = 5;
  localparam int WIDTH_MAX_NS  = 100;
  localparam int WIDTH_MIN_CYC = (WIDTH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIDTH_MAX_CYC = (WIDTH_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Dataway control lines that travel together.
  typedef struct packed {
    logic       n;
    logic [4:0] f;
    logic [3:0] a;
    logic       s1;
    logic       s2;
    logic       c;
    logic       z;
    logic       i;
  } dcc_dataway_t;

  // Complete state of the block.
  typedef struct packed {
    logic [NUM_CHAN-1:0]              prev_comp;
    logic [NUM_CHAN-1:0]              latch;
    logic [NUM_CHAN-1:0]              active;
    logic [NUM_CHAN-1:0][TIMER_W-1:0] timer;
    logic [NUM_CHAN-1:0]              mask;
    logic [SETTING_W-1:0]             thresh;
    logic [SETTING_W-1:0]             width;
    logic [MODE_W-1:0]                mode;
    logic [NUM_CHAN-1:0]              rd;
    logic [SETTING_W-1:0]             thr_out;
    logic [SETTING_W-1:0]             wid_out;
  } dcc_state_t;

endpackage

// ===== verification/dcc_channel_control_tb.sv
// Purpose: Self-checking bench for the discriminator channel control block.
// Assumes: High-true dataway levels; one 25 MHz clock.
// Notes:   Pulses come from the partner model; channel 1 is rear-inhibited, channel 4 mask-programmed.
`timescale 1ns/1ps
`default_nettype none
module dcc_channel_control_tb;
  logic                  core_clk, rst, start, veto_req, front_test, remote_mode, front_veto, q, qv, x, xv, busy;
  logic [3:0]            plen;
  logic [15:0]           chans, wdata, comp_out, rear_inhibit, read_data_bits, channel_out, rv, seen;
  logic [11:0]           thr_lvl, wid_lvl;
  dcc_pkg::dcc_dataway_t dw;
  int                    bad_count, compares, cycles, n_hi;
  logic [15:0]           wv [4] = '{16'h0010, 16'hFABC, 16'h0FFF, 16'hFFFD};
  logic [15:0]           ev [4] = '{16'h0010, 16'h0ABC, 16'h0FFF, 16'h0001};
  logic [11:0]           codes [3] = '{12'h000, 12'h800, 12'hFFF};
  logic [15:0]           widths [3] = '{16'h0003, 16'h0002, 16'h0001};

  dcc_channel_control dut (.core_clk(core_clk), .rst(rst), .dataway(dw), .write_data_bits(wdata),
    .comp_out(comp_out), .front_veto(front_veto), .rear_inhibit(rear_inhibit), .front_test(front_test),
    .remote_mode(remote_mode), .manual_threshold(12'h123), .manual_width(12'h456),
    .read_data_bits(read_data_bits), .q(q), .x(x), .channel_out(channel_out),
    .threshold_control_level(thr_lvl), .width_control_level(wid_lvl));
  dcc_pulse_source partner (.core_clk(core_clk), .rst(rst), .start(start), .chans(chans), .len(plen),
    .with_veto(veto_req), .comp_out(comp_out), .front_veto(front_veto), .busy(busy));

  // Free-running clock, 40 ns period.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // One dataway cycle; read data is sampled 1 ns after the take, and the request is held over the next edge so q and x are sampled while it stands.
  task automatic bus(input logic [4:0] fn, input logic [3:0] sa, input logic [15:0] d);
    @(posedge core_clk);
    dw.n <= 1'b1;
    dw.f <= fn;
    dw.a <= sa;
    dw.s1 <= 1'b1;
    wdata <= d;
    @(posedge core_clk);
    #1 rv = read_data_bits;
    qv = q;
    xv = x;
    @(posedge core_clk);
    dw.n <= 1'b0;
    dw.s1 <= 1'b0;
  endtask

  // Starts a pulse or a test level, then records every channel that fired and channel 0's high time.
  task automatic run(input logic [15:0] sel, input logic veto, input logic tst, input logic [3:0] len, input int hold);
    n_hi = 0;
    seen = 16'h0000;
    @(posedge core_clk);
    start <= !tst;
    front_test <= tst;
    chans <= sel;
    veto_req <= veto;
    plen <= len;
    for (int k = 1; k <= 18; k++)
    begin
      @(posedge core_clk);
      if (k == hold)
      begin
        start <= 1'b0;
        front_test <= 1'b0;
      end
      #1 seen = seen | channel_out;
      if (channel_out[0] === 1'b1) n_hi++;
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then the tests in order.
  initial
  begin
    {rst, start, veto_req, front_test, remote_mode, plen, chans, wdata, dw} = '0;
    rst = 1'b1;
    rear_inhibit = 16'h0002;
    {bad_count, compares, cycles} = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bus(dcc_pkg::FN_READ, 4'(i), 16'h0000);
      chk("reset value", 16'h0000, rv);
      bus(dcc_pkg::FN_WRITE, 4'(i), wv[i]);
      bus(dcc_pkg::FN_READ, 4'(i), 16'h0000);
      chk("read back", ev[i], rv);
      chk("q on read", 16'h0001, {15'h0000, qv});
      chk("x on read", 16'h0001, {15'h0000, xv});
    end
    bus(dcc_pkg::FN_READ, 4'h4, 16'h0000);
    chk("unmapped read", 16'h0000, rv);
    chk("unmapped q", 16'h0000, {15'h0000, qv});
    chk("unmapped x", 16'h0001, {15'h0000, xv});
    $display("Test registers done");
    #1 chk("local threshold", 16'h0123, {4'h0, thr_lvl});
    chk("local width", 16'h0456, {4'h0, wid_lvl});
    @(posedge core_clk);
    remote_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("remote threshold", 16'h0ABC, {4'h0, thr_lvl});
    chk("remote width", 16'h0FFF, {4'h0, wid_lvl});
    $display("Test source select done");
    bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_MODE, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_WIDTH, {4'h0, codes[i]});
      run(16'h0013, 1'b0, 1'b0, 4'h1, 1);
      chk("pulse width", widths[i], 16'(n_hi));
      chk("fired channels", 16'h0001, seen);
    end
    run(16'h0001, 1'b1, 1'b0, 4'h1, 1);
    chk("vetoed pulse", 16'h0000, seen);
    @(posedge core_clk);
    dw.i <= 1'b1;
    run(16'h0001, 1'b0, 1'b0, 4'h1, 1);
    chk("inhibited pulse", 16'h0000, seen);
    run(16'h0000, 1'b0, 1'b1, 4'h1, 1);
    chk("test channels", 16'hFFED, seen);
    @(posedge core_clk);
    dw.i <= 1'b0;
    $display("Test gating done");
    bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_WIDTH, 16'h0000);
    run(16'h0001, 1'b0, 1'b0, 4'h1, 4);
    chk("no retrigger", 16'h0003, 16'(n_hi));
    bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_MODE, 16'h0001);
    run(16'h0001, 1'b0, 1'b0, 4'h1, 4);
    chk("retrigger extends", 16'h0006, 16'(n_hi));
    bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_MODE, 16'h0002);
    run(16'h0001, 1'b0, 1'b0, 4'h8, 1);
    chk("burst guard width", 16'h0009, 16'(n_hi));
    $display("Test update done");
    @(posedge core_clk);
    dw.c <= 1'b1;
    dw.s2 <= 1'b1;
    @(posedge core_clk);
    dw.c <= 1'b0;
    dw.s2 <= 1'b0;
    bus(dcc_pkg::FN_READ, dcc_pkg::SA_MASK, 16'h0000);
    chk("mask cleared", 16'h0000, rv);
    run(16'h0010, 1'b0, 1'b0, 4'h1, 1);
    chk("unmasked channel", 16'h0010, seen);
    bus(dcc_pkg::FN_WRITE, dcc_pkg::SA_MASK, 16'h0001);
    bus(dcc_pkg::FN_TEST, 4'h0, 16'h0000);
    #1 chk("dataway test", 16'hFFFC, channel_out);
    chk("q on test", 16'h0001, {15'h0000, qv});
    chk("x on test", 16'h0001, {15'h0000, xv});
    $display("Test clear done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== verification/dcc_pulse_source.sv
// Purpose: Far-side model that drives comparator pulses and the front veto.
// Assumes: Comparator outputs idle high; a crossing is a high-to-low step.
// Notes:   A requested veto leads the pulse by one cycle and covers all of it.
`timescale 1ns/1ps
`default_nettype none
module dcc_pulse_source
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] chans,
  input  wire logic [3:0]  len,
  input  wire logic        with_veto,
  output logic      [15:0] comp_out,
  output logic             front_veto,
  output logic             busy
);
  logic [3:0]  cnt;
  logic [15:0] sel;
  logic [3:0]  plen;

  // One pulse per accepted start; a full cycle of veto lead is far more than the block needs.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      comp_out   <= 16'hFFFF;
      front_veto <= 1'b0;
      busy       <= 1'b0;
      cnt        <= 4'h0;
    end
    else if (start && !busy)
    begin
      busy       <= 1'b1;
      sel        <= chans;
      plen       <= len;
      cnt        <= 4'h0;
      front_veto <= with_veto;
    end
    else if (busy)
    begin
      cnt      <= cnt + 4'h1;
      comp_out <= (cnt < plen) ? ~sel : 16'hFFFF;
      if (cnt == plen)
      begin
        front_veto <= 1'b0;
        busy       <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
